// *** pat_pkg.sv ***
// Package: constants, opcodes, types for the page address translator
package pat_pkg;
  localparam int          PAT_PAGES      = 16;
  localparam int          PAT_PAGE_LSB   = 12;
  localparam int          PAT_PHYS_W     = 28;
  localparam logic [7:0]  PAT_OP_RD_LO   = 8'h82;
  localparam logic [7:0]  PAT_OP_RD_HI   = 8'h92;
  localparam logic [7:0]  PAT_OP_LD_LO   = 8'h80;
  localparam logic [7:0]  PAT_OP_LD_HI   = 8'h90;
  localparam logic [7:0]  PAT_OP_LDSWAP  = 8'h88;
  localparam logic [7:0]  PAT_OP_SWAP    = 8'h7F;
  localparam logic [5:0]  PAT_CLK_READ   = 6'h28;
  localparam logic [5:0]  PAT_CLK_LOAD   = 6'h2A;
  localparam logic [5:0]  PAT_CLK_SWAP   = 6'h08;
  localparam logic [15:0] PAT_ENTRY_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    PAT_IDLE = 3'b000,
    PAT_LOAD = 3'b001,
    PAT_READ = 3'b010,
    PAT_SWAP = 3'b011,
    PAT_TAIL = 3'b100
  } pat_state_t;

  // Memory-side transfer request issued by the block instructions
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } pat_xfer_t;

  // Identity value for page N
  function automatic logic [15:0] pat_ident(input logic [3:0] n);
    return {12'h000, n};
  endfunction
endpackage

// *** pat_map_table.sv ***
// Active and shadow map tables with byte loads and swap
`timescale 1ns/1ps
module pat_map_table
  import pat_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Shadow byte write
  input  wire logic        i_wr_en,
  input  wire logic        i_wr_hi,
  input  wire logic [3:0]  i_wr_idx,
  input  wire logic [7:0]  i_wr_data,
  // Exchange request
  input  wire logic        i_swap,
  // Lookups
  input  wire logic [3:0]  i_act_idx,
  output logic      [15:0] o_act_entry,
  input  wire logic [3:0]  i_shd_idx,
  output logic      [15:0] o_shd_entry
);
  logic [15:0] act      [PAT_PAGES];
  logic [15:0] shd      [PAT_PAGES];
  logic [15:0] next_act [PAT_PAGES];
  logic [15:0] next_shd [PAT_PAGES];

  // Byte writes touch only the shadow; swap exchanges whole tables
  always_comb begin
    for (int i = 0; i < PAT_PAGES; i++) begin
      next_act[i] = act[i];
      next_shd[i] = shd[i];
      if (i_wr_en && i_wr_idx == 4'(i)) begin
        if (i_wr_hi)
          next_shd[i][15:8] = i_wr_data;
        else
          next_shd[i][7:0] = i_wr_data;
      end
      if (i_swap) begin
        next_act[i] = shd[i];
        next_shd[i] = act[i];
      end
    end
  end

  // Identity map at reset in both copies
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < PAT_PAGES; i++) begin
        act[i] <= pat_ident(4'(i));
        shd[i] <= pat_ident(4'(i));
      end
    end else begin
      for (int i = 0; i < PAT_PAGES; i++) begin
        act[i] <= next_act[i];
        shd[i] <= next_shd[i];
      end
    end
  end

  assign o_act_entry = act[i_act_idx];
  assign o_shd_entry = shd[i_shd_idx];
endmodule

// *** pat_protect.sv ***
// Write and fetch inhibit checking with trap generation
`timescale 1ns/1ps
module pat_protect
  import pat_pkg::*;
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Access in progress
  input  wire logic i_mem_wr,
  input  wire logic i_fetch,
  // Raw inhibit pins
  input  wire logic i_wr_inh,
  input  wire logic i_exec_inh,
  // Results
  output logic      o_wr_allow,
  output logic      o_trap
);
  logic wr_s1, wr_s2, ex_s1, ex_s2;
  logic trap, next_trap;

  // Pins are outside the clock domain: two stages before use
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      ex_s1 <= 1'b0;
      ex_s2 <= 1'b0;
    end else begin
      wr_s1 <= i_wr_inh;
      wr_s2 <= wr_s1;
      ex_s1 <= i_exec_inh;
      ex_s2 <= ex_s1;
    end
  end

  // Registered trap, high in the cycle after each cycle of an offending access
  always_comb begin
    next_trap = (i_mem_wr && wr_s2) || (i_fetch && ex_s2);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      trap <= 1'b0;
    else
      trap <= next_trap;
  end

  assign o_wr_allow = i_mem_wr && !wr_s2;
  assign o_trap     = trap;
endmodule

// *** pat_translator.sv ***
// Page address translator: address path and map instruction sequencer
`timescale 1ns/1ps
module pat_translator
  import pat_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  // Logical access from the core
  input  wire logic [15:0]           i_log_addr,
  input  wire logic                  i_mem_req,
  input  wire logic                  i_io_req,
  input  wire logic                  i_mem_wr,
  input  wire logic                  i_fetch,
  // Map instruction issue (second opcode byte)
  input  wire logic                  i_op_valid,
  input  wire logic [7:0]            i_op_code,
  input  wire logic [15:0]           i_ptr,
  output logic                       o_busy,
  output logic                       o_done,
  // Memory transfer for block instructions
  output pat_xfer_t                  o_xfer,
  input  wire logic [7:0]            i_rd_data,
  // Protection pins
  input  wire logic                  i_wr_inh,
  input  wire logic                  i_exec_inh,
  // Physical side
  output logic [PAT_PHYS_W-1:0]      o_phys_addr,
  output logic [15:0]                o_io_addr,
  output logic                       o_mem_wr,
  output logic                       o_trap,
  // Interrupt and DMA gating
  output logic                       o_irq_block,
  output logic                       o_dma_block
);
  pat_state_t  state, next_state;
  logic [5:0]  cyc, next_cyc;
  logic [5:0]  limit, next_limit;
  logic [3:0]  idx, next_idx;
  logic [15:0] ptr, next_ptr;
  logic        hi, next_hi;
  logic        doswap, next_doswap;
  logic        done, next_done;
  pat_xfer_t   xfer, next_xfer;
  logic [PAT_PHYS_W-1:0] phys, next_phys;
  logic [15:0] ioa, next_ioa;
  logic        wen, wr_hi_sel, swp;
  logic [7:0]  wdata;
  logic [15:0] act_entry, shd_entry;

  // Decode the map opcodes; used only by the idle state to accept an opcode
  function automatic logic pat_is_map_op(input logic [7:0] op);
    return op == PAT_OP_RD_LO || op == PAT_OP_RD_HI ||
           op == PAT_OP_LD_LO || op == PAT_OP_LD_HI ||
           op == PAT_OP_LDSWAP || op == PAT_OP_SWAP;
  endfunction

  pat_map_table u_map (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_wr_en     (wen),
    .i_wr_hi     (wr_hi_sel),
    .i_wr_idx    (idx),
    .i_wr_data   (wdata),
    .i_swap      (swp),
    .i_act_idx   (i_log_addr[15:PAT_PAGE_LSB]),
    .i_shd_idx   (idx),
    .o_act_entry (act_entry),
    .o_shd_entry (shd_entry)
  );

  pat_protect u_prot (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_mem_wr   (i_mem_wr),
    .i_fetch    (i_fetch),
    .i_wr_inh   (i_wr_inh),
    .i_exec_inh (i_exec_inh),
    .o_wr_allow (o_mem_wr),
    .o_trap     (o_trap)
  );

  // Address path notes:
  //   the active table is read combinationally by the page index and the
  //   result is registered together with the low offset, so the physical
  //   address stands from the cycle after the request until the next one.
  //   I/O addresses are registered separately and never see the tables;
  //   a DMA engine driving the I/O port therefore cannot reach them.
  //   Spare upper entry bits leave as plain address bits; wiring one of
  //   them back to an inhibit pin is a board-level choice.
  // Address path: tables sit behind the memory port only, never I/O
  always_comb begin
    next_phys = phys;
    next_ioa  = ioa;
    if (i_mem_req)
      next_phys = {act_entry, i_log_addr[PAT_PAGE_LSB-1:0]};
    if (i_io_req)
      next_ioa = i_log_addr;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phys <= '0;
      ioa  <= '0;
    end else begin
      phys <= next_phys;
      ioa  <= next_ioa;
    end
  end

  // Sequencer timing, counted from the edge that takes the opcode, which
  // leaves the cycle counter at one:
  //   swap         exchange at the next edge, then pad in the tail state
  //   block load   read strobe stands in even cycles 2 to 32, data is
  //                captured in odd cycles 3 to 33, entry k at cycle 2k+3
  //   block read   write strobe stands in odd cycles 3 to 33 with the
  //                shadow byte of entry k and pointer plus k
  //   load + swap  as block load, the exchange lands on the last edge
  // In every case done stands in the cycle whose count equals the limit.
  // The tail state burns clocks, and makes the load + swap exchange, so that the core sees the same
  // instruction length whatever the transfer pattern was; it also keeps
  // the interrupt and DMA gates closed for the whole instruction.
  // Limitation: the counter is six bits wide, so a limit above 63 would
  // wrap; every documented length fits with room to spare.
  // Sequencer: one transfer per two clocks, then pad to the cycle count
  always_comb begin
    next_state  = state;
    next_cyc    = cyc + 6'h01;
    next_limit  = limit;
    next_idx    = idx;
    next_ptr    = ptr;
    next_hi     = hi;
    next_doswap = doswap;
    next_done   = 1'b0;
    next_xfer   = '0;
    wen         = 1'b0;
    wr_hi_sel   = hi;
    wdata       = i_rd_data;
    swp         = 1'b0;
    case (state)
      PAT_IDLE: begin
        next_cyc = 6'h00;
        if (i_op_valid && pat_is_map_op(i_op_code)) begin
          next_ptr    = i_ptr;
          next_idx    = 4'h0;
          next_cyc    = 6'h01;
          next_hi     = i_op_code == PAT_OP_RD_HI || i_op_code == PAT_OP_LD_HI;
          next_doswap = i_op_code == PAT_OP_LDSWAP;
          if (i_op_code == PAT_OP_SWAP) begin
            next_state = PAT_SWAP;
            next_limit = PAT_CLK_SWAP;
          end else if (i_op_code == PAT_OP_RD_LO ||
                       i_op_code == PAT_OP_RD_HI) begin
            next_state = PAT_READ;
            next_limit = PAT_CLK_READ;
          end else begin
            next_state = PAT_LOAD;
            next_limit = PAT_CLK_LOAD;
          end
        end
      end
      PAT_LOAD: begin
        // Odd cycles only: capture the byte asked for two clocks back,
        // then ask for the next one. The read strobe is registered and
        // memory answers a cycle after it sees the strobe, so capturing
        // in the strobe's own cycle would take stale data.
        if (cyc[0]) begin
          if (cyc > 6'h01) begin
            wen      = 1'b1;
            next_ptr = ptr + 16'h0001;
            next_idx = idx + 4'h1;
            if (idx == 4'hF)
              next_state = PAT_TAIL;
          end
          // No seventeenth read once the last entry is captured
          if (!(cyc > 6'h01 && idx == 4'hF)) begin
            next_xfer.rd   = 1'b1;
            next_xfer.addr = next_ptr;
          end
        end
      end
      PAT_READ: begin
        if (!cyc[0]) begin
          next_xfer.wr   = 1'b1;
          next_xfer.addr = ptr;
          next_xfer.data = hi ? shd_entry[15:8] : shd_entry[7:0];
          next_ptr       = ptr + 16'h0001;
          next_idx       = idx + 4'h1;
          if (idx == 4'hF)
            next_state = PAT_TAIL;
        end
      end
      PAT_SWAP: begin
        next_state = PAT_TAIL;
        swp        = 1'b1;
      end
      PAT_TAIL: begin
        if (cyc == limit - 6'h01) begin
          next_state = PAT_IDLE;
          next_done  = 1'b1;
          swp        = doswap;
        end
      end
      default: begin
        next_state = PAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state  <= PAT_IDLE;
      cyc    <= 6'h00;
      limit  <= 6'h00;
      idx    <= 4'h0;
      ptr    <= 16'h0000;
      hi     <= 1'b0;
      doswap <= 1'b0;
      done   <= 1'b0;
      xfer   <= '0;
    end else begin
      state  <= next_state;
      cyc    <= next_cyc;
      limit  <= next_limit;
      idx    <= next_idx;
      ptr    <= next_ptr;
      hi     <= next_hi;
      doswap <= next_doswap;
      done   <= next_done;
      xfer   <= next_xfer;
    end
  end

  // Interrupt and DMA blocks cover busy and the done cycle after it, so no
  // interrupt is sampled at its end and the next opcode runs first
  assign o_busy      = state != PAT_IDLE;
  assign o_irq_block = o_busy || done;
  assign o_dma_block = o_busy || done;
  assign o_done      = done;
  assign o_xfer      = xfer;
  assign o_phys_addr = phys;
  assign o_io_addr   = ioa;
  // Trap only jumps the core to zero; maps are left as they stand.
  // A mapped page 0 therefore still applies after a trap, whereas reset
  // brings back the identity map before the first fetch.
endmodule

// *** pat_mem_model.sv ***
// Byte memory standing in for the core's bus during block transfers
`timescale 1ns/1ps
module pat_mem_model
  import pat_pkg::*;
(
  // Clock
  input  wire logic      i_mclk,
  // Transfer request from the translator
  input  wire pat_xfer_t i_xfer,
  // Read data, valid the cycle after a read strobe
  output logic [7:0]     o_rd_data
);
  logic [7:0] mem [256];

  // Fixed pattern that the bench also knows
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    o_rd_data = 8'h00;
  end

  // Data toggles outside a read slot so a late sample never looks valid
  always @(posedge i_mclk) begin
    if (i_xfer.rd) begin
      o_rd_data <= mem[i_xfer.addr[7:0]];
    end else begin
      o_rd_data <= ~o_rd_data;
    end
    if (i_xfer.wr) begin
      mem[i_xfer.addr[7:0]] <= i_xfer.data;
    end
  end
endmodule

// *** pat_translator_monitor.sv ***
// Port checker for the page address translator
`timescale 1ns/1ps
module pat_translator_monitor
  import pat_pkg::*;
(
  // Clock and reset
  input wire logic                  i_mclk,
  input wire logic                  i_rst_n,
  // Core side
  input wire logic [15:0]           i_log_addr,
  input wire logic                  i_mem_req,
  input wire logic                  i_io_req,
  input wire logic                  i_mem_wr,
  input wire logic                  i_fetch,
  input wire logic                  i_op_valid,
  input wire logic [7:0]            i_op_code,
  input wire logic                  o_busy,
  input wire logic                  o_done,
  // Protection and physical side
  input wire logic                  i_wr_inh,
  input wire logic                  i_exec_inh,
  input wire logic [PAT_PHYS_W-1:0] o_phys_addr,
  input wire logic [15:0]           o_io_addr,
  input wire logic                  o_mem_wr,
  input wire logic                  o_trap,
  input wire logic                  o_irq_block,
  input wire logic                  o_dma_block
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Only an idle sequencer accepts an opcode
  logic issue;
  assign issue = i_op_valid && !o_busy;

  property p_low_pass;
    i_mem_req |=> o_phys_addr[11:0] == $past(i_log_addr[11:0]);
  endproperty
  a_low_pass: assert property (p_low_pass)
    else $error("low address bits altered");
  property p_io_pass;
    i_io_req |=> o_io_addr == $past(i_log_addr);
  endproperty
  a_io_pass: assert property (p_io_pass)
    else $error("io address altered");
  property p_swap_len;
    issue && i_op_code == PAT_OP_SWAP |=> !o_done [*7] ##1 o_done;
  endproperty
  a_swap_len: assert property (p_swap_len)
    else $error("swap length wrong");
  property p_load_len;
    issue && (i_op_code == PAT_OP_LD_LO || i_op_code == PAT_OP_LD_HI)
      |-> ##42 o_done;
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("load length wrong");
  property p_read_len;
    issue && (i_op_code == PAT_OP_RD_LO || i_op_code == PAT_OP_RD_HI)
      |-> ##40 o_done;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read length wrong");
  property p_ldsw_len;
    issue && i_op_code == PAT_OP_LDSWAP |-> ##42 o_done;
  endproperty
  a_ldsw_len: assert property (p_ldsw_len)
    else $error("load and swap length wrong");
  property p_atomic;
    o_busy |-> o_irq_block && o_dma_block;
  endproperty
  a_atomic: assert property (p_atomic)
    else $error("grant open while busy");
  property p_tail;
    o_done |-> o_irq_block && o_dma_block && $past(o_busy);
  endproperty
  a_tail: assert property (p_tail)
    else $error("grant open at instruction end");
  property p_wr_gate;
    i_wr_inh [*3] |-> !o_mem_wr;
  endproperty
  a_wr_gate: assert property (p_wr_gate)
    else $error("write strobe not suppressed");
  property p_wr_trap;
    (i_mem_wr && i_wr_inh) [*3] |=> o_trap;
  endproperty
  a_wr_trap: assert property (p_wr_trap)
    else $error("no trap on inhibited write");
  property p_fetch_trap;
    (i_fetch && i_exec_inh) [*3] |=> o_trap;
  endproperty
  a_fetch_trap: assert property (p_fetch_trap)
    else $error("no trap on inhibited fetch");
  property p_no_trap;
    (!i_wr_inh && !i_exec_inh) [*4] |=> !o_trap;
  endproperty
  a_no_trap: assert property (p_no_trap)
    else $error("trap without inhibit");

  c_swap: cover property (issue && i_op_code == PAT_OP_SWAP);
  c_done: cover property (o_done);
  c_trap: cover property (o_trap);
endmodule

bind pat_translator pat_translator_monitor u_mon (.i_mclk(i_mclk),
  .i_rst_n(i_rst_n), .i_log_addr(i_log_addr), .i_mem_req(i_mem_req),
  .i_io_req(i_io_req), .i_mem_wr(i_mem_wr), .i_fetch(i_fetch),
  .i_op_valid(i_op_valid), .i_op_code(i_op_code), .o_busy(o_busy),
  .o_done(o_done), .i_wr_inh(i_wr_inh), .i_exec_inh(i_exec_inh),
  .o_phys_addr(o_phys_addr), .o_io_addr(o_io_addr), .o_mem_wr(o_mem_wr),
  .o_trap(o_trap), .o_irq_block(o_irq_block), .o_dma_block(o_dma_block));

// *** pat_translator_bench.sv ***
// Self-checking bench for the page address translator
`timescale 1ns/1ps
module pat_translator_bench
  import pat_pkg::*;
;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_mem_req = 1'b0, i_io_req = 1'b0;
  logic i_mem_wr = 1'b0, i_fetch = 1'b0, i_op_valid = 1'b0;
  logic i_wr_inh = 1'b0, i_exec_inh = 1'b0;
  logic [15:0] i_log_addr = 16'h0000, i_ptr = 16'h0000, o_io_addr;
  logic [7:0]  i_op_code = 8'h00, i_rd_data;
  logic [27:0] o_phys_addr;
  logic        o_busy, o_done, o_mem_wr, o_trap, o_irq_block, o_dma_block;
  pat_xfer_t   o_xfer;
  logic [15:0] exp_act [16];
  int          errors = 0, checks_done = 0, cyc = 0;

  pat_translator dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_log_addr(i_log_addr), .i_mem_req(i_mem_req), .i_io_req(i_io_req),
    .i_mem_wr(i_mem_wr), .i_fetch(i_fetch), .i_op_valid(i_op_valid),
    .i_op_code(i_op_code), .i_ptr(i_ptr), .o_busy(o_busy),
    .o_done(o_done), .o_xfer(o_xfer), .i_rd_data(i_rd_data),
    .i_wr_inh(i_wr_inh), .i_exec_inh(i_exec_inh),
    .o_phys_addr(o_phys_addr), .o_io_addr(o_io_addr), .o_mem_wr(o_mem_wr),
    .o_trap(o_trap), .o_irq_block(o_irq_block), .o_dma_block(o_dma_block));
  pat_mem_model u_mem (.i_mclk(i_mclk), .i_xfer(o_xfer),
    .o_rd_data(i_rd_data));

  initial begin
    forever #4 i_mclk = ~i_mclk;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [27:0] seen,
                     input logic [27:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] byte_at(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  // One access; outputs are judged at the next falling edge
  task automatic acc(input logic [15:0] a, input logic io);
    @(negedge i_mclk);
    i_log_addr = a;
    i_mem_req = !io;
    i_io_req = io;
    @(negedge i_mclk);
    i_mem_req = 1'b0;
    i_io_req = 1'b0;
  endtask

  task automatic chk_map();
    for (int p = 0; p < 16; p++) begin
      acc({p[3:0], 12'hA5C}, 1'b0);
      chk("phys", o_phys_addr, {exp_act[p], 12'hA5C});
    end
  endtask

  // The cycle after the issue edge counts as one; done is seen in the cycle that ends the op
  task automatic run_op(input logic [7:0] op, input logic [15:0] ptr,
                        input int clocks);
    int n;
    @(negedge i_mclk);
    i_op_valid = 1'b1;
    i_op_code = op;
    i_ptr = ptr;
    @(negedge i_mclk);
    i_op_valid = 1'b0;
    n = 1;
    chk("irq_block", 28'(o_irq_block), 28'h1);
    chk("dma_block", 28'(o_dma_block), 28'h1);
    while (o_done !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
    chk("op_clocks", 28'(n), 28'(clocks));
    chk("tail_block", 28'(o_irq_block), 28'h1);
  endtask

  task automatic t_reset_map();
    for (int i = 0; i < 16; i++) exp_act[i] = {12'h000, i[3:0]};
    chk_map();
    acc(16'hF123, 1'b1);
    chk("io_addr", 28'(o_io_addr), 28'hF123);
    chk("io_phys", o_phys_addr, 28'h000FA5C);
  endtask

  task automatic t_loads();
    run_op(PAT_OP_LD_LO, 16'h0000, 42);
    chk_map();
    run_op(PAT_OP_SWAP, 16'h0000, 8);
    for (int i = 0; i < 16; i++) exp_act[i] = {8'h00, byte_at(8'(i))};
    chk_map();
    run_op(PAT_OP_LD_HI, 16'h0020, 42);
    run_op(PAT_OP_SWAP, 16'h0000, 8);
    for (int i = 0; i < 16; i++)
      exp_act[i] = {byte_at(8'h20 + 8'(i)), 4'h0, i[3:0]};
    chk_map();
  endtask

  // Shadow holds the lower-byte map here; the second read sees zeros
  task automatic t_read_back();
    run_op(PAT_OP_RD_LO, 16'h0080, 40);
    run_op(PAT_OP_RD_HI, 16'h00A0, 40);
    for (int i = 0; i < 16; i++) begin
      chk("rd_lo", 28'(u_mem.mem[8'h80 + i]), 28'(byte_at(8'(i))));
      chk("rd_hi", 28'(u_mem.mem[8'hA0 + i]), 28'h0);
    end
  endtask

  task automatic t_load_swap();
    run_op(PAT_OP_LDSWAP, 16'h0040, 42);
    for (int i = 0; i < 16; i++)
      exp_act[i] = {8'h00, byte_at(8'h40 + 8'(i))};
    chk_map();
    run_op(PAT_OP_RD_HI, 16'h00C0, 40);
    for (int i = 0; i < 16; i++)
      chk("old_act", 28'(u_mem.mem[8'hC0 + i]),
          28'(byte_at(8'h20 + 8'(i))));
  endtask

  task automatic t_bad_op();
    @(negedge i_mclk);
    i_op_valid = 1'b1;
    i_op_code = 8'h00;
    @(negedge i_mclk);
    i_op_valid = 1'b0;
    @(negedge i_mclk);
    chk("bad_op", 28'(o_busy), 28'h0);
  endtask

  // Pins pass a two-flop synchroniser, so hold them four cycles
  task automatic t_inhibit();
    i_mem_wr = 1'b1;
    i_wr_inh = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk("wr_gate", 28'(o_mem_wr), 28'h0);
    chk("wr_trap", 28'(o_trap), 28'h1);
    i_wr_inh = 1'b0;
    repeat (4) @(negedge i_mclk);
    chk("wr_pass", 28'(o_mem_wr), 28'h1);
    i_mem_wr = 1'b0;
    i_fetch = 1'b1;
    i_exec_inh = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk("fetch_trap", 28'(o_trap), 28'h1);
    i_fetch = 1'b0;
    i_exec_inh = 1'b0;
    repeat (4) @(negedge i_mclk);
    chk("trap_idle", 28'(o_trap), 28'h0);
    chk_map();
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'b1;
    for (int i = 0; i < 16; i++) exp_act[i] = {12'h000, i[3:0]};
    chk_map();
  endtask

  initial begin
    repeat (4) @(negedge i_mclk);
    i_rst_n = 1'b1;
    t_reset_map();
    t_loads();
    t_read_back();
    t_load_swap();
    t_bad_op();
    t_inhibit();
    give_verdict();
  end
endmodule
